// >>> verilog/slf_defs.svh
// constants for the store-to-load forwarding block
// assumes byte addresses of 48 bits and store data of up to 16 bytes
`ifndef SLF_DEFS_SVH
`define SLF_DEFS_SVH

// ==========================================================
// widths
`define SLF_AW        48
`define SLF_DW        128
`define SLF_SB_DEPTH  4

// ==========================================================
// operand sizes in bytes
`define SLF_N_BYTE    5'h01
`define SLF_N_WORD    5'h02
`define SLF_N_DWORD   5'h04
`define SLF_N_QWORD   5'h08
`define SLF_N_TBYTE   5'h0A
`define SLF_N_DQWORD  5'h10
`define SLF_N_BANK    5'h10

// ==========================================================
// natural alignment: address bits that must be zero
`define SLF_AL_BYTE   4'h0
`define SLF_AL_WORD   4'h1
`define SLF_AL_DWORD  4'h3
`define SLF_AL_QWORD  4'h7
`define SLF_AL_TBYTE  4'h7
`define SLF_AL_DQWORD 4'hF

// ==========================================================
// two-stage address match and upper-quadword offset
`define SLF_S1_HI     11
`define SLF_S1_LO     4
`define SLF_UPPER_OFS 48'h0000_0000_0008

// ==========================================================
// timing
`define SLF_ALIGN_PEN_CYC 1

`endif

// >>> verilog/slf_pkg.sv
// types and helpers shared by the forwarding block and its comparator
// assumes slf_defs.svh is on the include path
`include "slf_defs.svh"

package slf_pkg;

   // ==========================================================
   // operand sizes and transfer records
   typedef enum logic [2:0] {SZ_BYTE, SZ_WORD, SZ_DWORD, SZ_QWORD, SZ_TBYTE, SZ_DQWORD} size_t;

   typedef struct packed {
      logic [`SLF_AW-1:0] addr;
      size_t              size;
   } acc_t;

   typedef struct packed {
      acc_t               acc;
      logic [`SLF_DW-1:0] data;
   } st_req_t;

   typedef struct packed {
      logic [`SLF_DW-1:0] data;
      logic               fwd;
      logic               fault;
   } ld_rsp_t;

   typedef enum logic [2:0] {L_IDLE, L_PEN, L_LOOK, L_CHECK, L_WAIT, L_RD, L_RSP} ld_state_t;

   // ==========================================================
   // helpers
   function automatic logic [4:0] size_bytes(input size_t s);
      case (s)
         SZ_BYTE:   size_bytes = `SLF_N_BYTE;
         SZ_WORD:   size_bytes = `SLF_N_WORD;
         SZ_DWORD:  size_bytes = `SLF_N_DWORD;
         SZ_QWORD:  size_bytes = `SLF_N_QWORD;
         SZ_TBYTE:  size_bytes = `SLF_N_TBYTE;
         SZ_DQWORD: size_bytes = `SLF_N_DQWORD;
         default:   size_bytes = `SLF_N_BYTE;
      endcase
   endfunction

   // ten-byte objects only need quadword alignment
   function automatic logic is_aligned(input logic [3:0] a, input size_t s);
      logic [3:0] m;
      case (s)
         SZ_BYTE:   m = `SLF_AL_BYTE;
         SZ_WORD:   m = `SLF_AL_WORD;
         SZ_DWORD:  m = `SLF_AL_DWORD;
         SZ_QWORD:  m = `SLF_AL_QWORD;
         SZ_TBYTE:  m = `SLF_AL_TBYTE;
         SZ_DQWORD: m = `SLF_AL_DQWORD;
         default:   m = `SLF_AL_BYTE;
      endcase
      is_aligned = ((a & m) == 4'h0);
   endfunction

endpackage

// >>> verilog/slf_entry_cmp.sv
// compares one store-buffer entry against the load being looked up
// assumes purely combinational use; the caller qualifies by entry age
`timescale 1ns/1ps
`default_nettype none
`include "slf_defs.svh"

module slf_entry_cmp (
   input  wire logic           i_valid,
   input  wire slf_pkg::acc_t  i_st,
   input  wire slf_pkg::acc_t  i_ld,
   output logic                o_part_hit,
   output logic                o_overlap,
   output logic                o_fwd_ok,
   output logic                o_narrow_dw
);

   // ==========================================================
   // doublewords touched inside one 16-byte bank
   function automatic logic [3:0] dw_mask(input logic [3:0] a, input logic [4:0] n);
      logic [4:0] last;
      logic [1:0] lst;
      last = {1'b0, a} + n - 5'h01;
      lst  = last[4] ? 2'h3 : last[3:2];
      for (int k = 0; k < 4; k++)
         dw_mask[k] = (2'(k) >= a[3:2]) && (2'(k) <= lst);
   endfunction

   logic [4:0]        st_n;
   logic [4:0]        ld_n;
   logic [`SLF_AW:0]  st_end;
   logic [`SLF_AW:0]  ld_end;
   logic              same_start;
   logic              upper_q;
   logic              both_al;

   assign st_n   = slf_pkg::size_bytes(i_st.size);
   assign ld_n   = slf_pkg::size_bytes(i_ld.size);
   assign st_end = {1'b0, i_st.addr} + {{(`SLF_AW-4){1'b0}}, st_n};
   assign ld_end = {1'b0, i_ld.addr} + {{(`SLF_AW-4){1'b0}}, ld_n};

   // early match on the bank index and doubleword mask only
   assign o_part_hit = i_valid
                     && (i_st.addr[`SLF_S1_HI:`SLF_S1_LO] == i_ld.addr[`SLF_S1_HI:`SLF_S1_LO])
                     && ((dw_mask(i_st.addr[3:0], st_n) & dw_mask(i_ld.addr[3:0], ld_n)) != 4'h0);

   assign o_overlap = i_valid && ({1'b0, i_ld.addr} < st_end) && ({1'b0, i_st.addr} < ld_end);

   assign same_start = (i_st.addr == i_ld.addr);
   assign upper_q    = (i_st.size == slf_pkg::SZ_DQWORD)
                     && (i_ld.addr == i_st.addr + `SLF_UPPER_OFS)
                     && (ld_n <= `SLF_N_QWORD);
   assign both_al    = slf_pkg::is_aligned(i_st.addr[3:0], i_st.size)
                     && slf_pkg::is_aligned(i_ld.addr[3:0], i_ld.size);

   // wide-to-narrow at the same start is fine, narrow-to-wide never
   assign o_fwd_ok = i_valid && both_al && ((same_start && (ld_n <= st_n)) || upper_q);

   assign o_narrow_dw = i_valid && (st_n <= `SLF_N_WORD)
                      && (i_st.addr[`SLF_AW-1:2] == i_ld.addr[`SLF_AW-1:2]);

endmodule

`default_nettype wire

// >>> verilog/store_load_forward.sv
// store buffer with store-to-load forwarding for the load_store_unit
// assumes stores arrive in program order and the reorder buffer pulses once per retired store
`timescale 1ns/1ps
`default_nettype none
`include "slf_defs.svh"

module store_load_forward #(
   parameter int DEPTH     = `SLF_SB_DEPTH,
   parameter int ALIGN_PEN = `SLF_ALIGN_PEN_CYC
) (
   input  wire logic              I_MCLK,
   input  wire logic              I_RST_N,
   input  wire logic              I_ALIGN_MASK,
   input  wire logic              I_ST_VALID,
   input  wire slf_pkg::st_req_t  I_ST,
   output logic                   O_ST_READY,
   input  wire logic              I_ROB_STORE_RETIRE,
   output logic                   O_DC_WR_VALID,
   output slf_pkg::st_req_t       O_DC_WR,
   input  wire logic              I_DC_WR_READY,
   input  wire logic              I_LD_VALID,
   input  wire slf_pkg::acc_t     I_LD,
   output logic                   O_LD_READY,
   output logic                   O_DC_RD_VALID,
   output slf_pkg::acc_t          O_DC_RD,
   input  wire logic              I_DC_RD_DONE,
   input  wire logic [`SLF_DW-1:0] I_DC_RD_DATA,
   output logic                   O_LD_DONE,
   output slf_pkg::ld_rsp_t       O_LD_RSP,
   output logic                   O_LD_RETRY
);

   // depth must be a power of two so that pointers wrap for free
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // ==========================================================
   // store buffer state
   slf_pkg::st_req_t  ent_q [DEPTH];
   logic [DEPTH-1:0]  valid_q;
   logic [DEPTH-1:0]  commit_q;
   logic [PW-1:0]     head_q;
   logic [PW-1:0]     tail_q;
   logic [PW-1:0]     cmt_q;
   logic [PW:0]       count_q;
   logic [3:0]        st_pen_q;

   logic              enq;
   logic              deq;
   logic              st_al;

   assign st_al         = slf_pkg::is_aligned(I_ST.acc.addr[3:0], I_ST.acc.size);
   assign O_ST_READY    = (count_q != (PW+1)'(DEPTH)) && (st_pen_q == 4'h0);
   assign enq           = I_ST_VALID && O_ST_READY;
   // only a store the reorder buffer has retired may reach the cache
   assign O_DC_WR_VALID = valid_q[head_q] && commit_q[head_q];
   assign O_DC_WR       = ent_q[head_q];
   assign deq           = O_DC_WR_VALID && I_DC_WR_READY;

   always_ff @(posedge I_MCLK)
   begin
      if (enq)
         ent_q[tail_q] <= I_ST;
   end

   always_ff @(posedge I_MCLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         valid_q  <= '0;
         commit_q <= '0;
      end
      else
      begin
         if (deq)
         begin
            valid_q[head_q]  <= 1'b0;
            commit_q[head_q] <= 1'b0;
         end
         if (enq)
            valid_q[tail_q] <= 1'b1;
         if (I_ROB_STORE_RETIRE)
            commit_q[cmt_q] <= 1'b1;
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         head_q   <= '0;
         tail_q   <= '0;
         cmt_q    <= '0;
         count_q  <= '0;
         st_pen_q <= 4'h0;
      end
      else
      begin
         head_q  <= head_q + PW'(deq);
         tail_q  <= tail_q + PW'(enq);
         cmt_q   <= cmt_q + PW'(I_ROB_STORE_RETIRE);
         count_q <= count_q + (PW+1)'(enq) - (PW+1)'(deq);
         if (enq && !st_al)
            st_pen_q <= 4'(ALIGN_PEN);
         else if (st_pen_q != 4'h0)
            st_pen_q <= st_pen_q - 4'h1;
      end
   end

   // ==========================================================
   // per-entry comparison against the load in flight
   slf_pkg::ld_state_t state_q;
   slf_pkg::acc_t      ld_q;
   slf_pkg::ld_rsp_t   rsp_q;
   logic [DEPTH-1:0]   older_q;
   logic [DEPTH-1:0]   part_hit;
   logic [DEPTH-1:0]   overlap;
   logic [DEPTH-1:0]   fwd_ok;
   logic [DEPTH-1:0]   narrow_dw;
   logic [DEPTH-1:0]   older_now;

   assign older_now = older_q & valid_q;

   for (genvar g = 0; g < DEPTH; g++)
   begin : g_cmp
      slf_entry_cmp u_cmp (
         .i_valid     (older_now[g]),
         .i_st        (ent_q[g].acc),
         .i_ld        (ld_q),
         .o_part_hit  (part_hit[g]),
         .o_overlap   (overlap[g]),
         .o_fwd_ok    (fwd_ok[g]),
         .o_narrow_dw (narrow_dw[g])
      );
   end

   // ==========================================================
   // youngest-match selection, oldest to youngest walk
   logic [PW-1:0] sel1;
   logic          any1;
   logic [PW-1:0] sel2;
   logic          any2;
   logic          conflict;
   logic [PW-1:0] slot;

   always_comb
   begin
      slot     = '0;
      sel1     = '0;
      any1     = 1'b0;
      sel2     = '0;
      any2     = 1'b0;
      conflict = 1'b0;
      for (int k = 0; k < DEPTH; k++)
      begin
         slot = head_q + PW'(k);
         if (part_hit[slot])
         begin
            sel1 = slot;
            any1 = 1'b1;
         end
         if (overlap[slot])
         begin
            sel2     = slot;
            any2     = 1'b1;
            conflict = 1'b0;
         end
         else if (narrow_dw[slot] && any2)
            conflict = 1'b1;
      end
   end

   // ==========================================================
   // load sequencer
   logic              ld_acc;
   logic              ld_al;
   logic              narrow_ld;
   logic              fwd_go;
   logic              false_hit;
   logic              retry_q;
   logic              hit1_q;
   logic              fault_q;
   logic [PW-1:0]     sel1_q;
   logic [PW-1:0]     wait_q;
   logic [3:0]        pen_q;
   logic [4:0]        ld_n;
   logic [6:0]        fwd_shift;
   logic [`SLF_DW-1:0] byte_mask;
   logic [`SLF_DW-1:0] fwd_data;
   logic [DEPTH-1:0]  enq_hot;

   assign O_LD_READY = (state_q == slf_pkg::L_IDLE);
   assign ld_acc     = I_LD_VALID && O_LD_READY;
   assign ld_al      = slf_pkg::is_aligned(I_LD.addr[3:0], I_LD.size);
   assign ld_n       = slf_pkg::size_bytes(ld_q.size);
   assign narrow_ld  = (ld_n <= `SLF_N_WORD);
   assign enq_hot    = enq ? (DEPTH'(1) << tail_q) : '0;
   // early hit that the full compare rejects: cancel instead of forwarding
   assign false_hit  = (state_q == slf_pkg::L_CHECK) && hit1_q && !retry_q && !overlap[sel1_q];
   assign fwd_go     = (state_q == slf_pkg::L_CHECK) && !false_hit && any2 && fwd_ok[sel2]
                     && !(conflict && narrow_ld);
   assign fwd_shift  = {ld_q.addr[3:0] - ent_q[sel2].acc.addr[3:0], 3'b000};
   assign byte_mask  = {`SLF_DW{1'b1}} >> {`SLF_N_BANK - ld_n, 3'b000};
   assign fwd_data   = (ent_q[sel2].data >> fwd_shift) & byte_mask;

   assign O_LD_RETRY    = false_hit;
   assign O_DC_RD_VALID = (state_q == slf_pkg::L_RD);
   assign O_DC_RD       = ld_q;
   assign O_LD_DONE     = (state_q == slf_pkg::L_RSP);
   assign O_LD_RSP      = rsp_q;

   always_ff @(posedge I_MCLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         state_q <= slf_pkg::L_IDLE;
         pen_q   <= 4'h0;
         retry_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            slf_pkg::L_IDLE:
               if (ld_acc)
               begin
                  state_q <= ld_al ? slf_pkg::L_LOOK : slf_pkg::L_PEN;
                  pen_q   <= 4'(ALIGN_PEN - 1);
                  retry_q <= 1'b0;
               end
            slf_pkg::L_PEN:
               if (pen_q != 4'h0)
                  pen_q <= pen_q - 4'h1;
               else
                  state_q <= fault_q ? slf_pkg::L_RSP : slf_pkg::L_LOOK;
            slf_pkg::L_LOOK:
               state_q <= slf_pkg::L_CHECK;
            slf_pkg::L_CHECK:
               if (false_hit)
               begin
                  state_q <= slf_pkg::L_LOOK;
                  retry_q <= 1'b1;
               end
               else if (!any2)
                  state_q <= slf_pkg::L_RD;
               else if (fwd_go)
                  state_q <= slf_pkg::L_RSP;
               else
                  state_q <= slf_pkg::L_WAIT;
            slf_pkg::L_WAIT:
               if (!valid_q[wait_q])
                  state_q <= slf_pkg::L_RD;
            slf_pkg::L_RD:
               if (I_DC_RD_DONE)
                  state_q <= slf_pkg::L_RSP;
            slf_pkg::L_RSP:
               state_q <= slf_pkg::L_IDLE;
            default:
               state_q <= slf_pkg::L_IDLE;
         endcase
      end
   end

   // the retry compares all address bits, so a second false hit cannot occur
   always_ff @(posedge I_MCLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         ld_q    <= '0;
         older_q <= '0;
         fault_q <= 1'b0;
         hit1_q  <= 1'b0;
         sel1_q  <= '0;
         wait_q  <= '0;
      end
      else
      begin
         if (ld_acc)
         begin
            ld_q    <= I_LD;
            older_q <= valid_q | enq_hot;
            fault_q <= !ld_al && I_ALIGN_MASK;
         end
         if (state_q == slf_pkg::L_LOOK)
         begin
            hit1_q <= retry_q ? any2 : any1;
            sel1_q <= retry_q ? sel2 : sel1;
         end
         if (state_q == slf_pkg::L_CHECK)
            wait_q <= sel2;
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
         rsp_q <= '0;
      else if (state_q == slf_pkg::L_PEN && pen_q == 4'h0 && fault_q)
         rsp_q <= '{data: '0, fwd: 1'b0, fault: 1'b1};
      else if (fwd_go)
         rsp_q <= '{data: fwd_data, fwd: 1'b1, fault: 1'b0};
      else if (state_q == slf_pkg::L_RD && I_DC_RD_DONE)
         rsp_q <= '{data: I_DC_RD_DATA & byte_mask, fwd: 1'b0, fault: 1'b0};
   end

   // ==========================================================
   // checks
   logic [PW+1:0] pend_q;

   always_ff @(posedge I_MCLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
         pend_q <= '0;
      else
         pend_q <= pend_q + (PW+2)'(I_ROB_STORE_RETIRE) - (PW+2)'(deq);
   end

   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_N);

   property p_st_pen;
      enq && !st_al |=> !O_ST_READY;
   endproperty
   a_st_pen: assert property (p_st_pen) else $error("misaligned store got no bubble");

   property p_ld_pen;
      ld_acc && !ld_al && !I_ALIGN_MASK |=> !O_LD_DONE [*3];
   endproperty
   a_ld_pen: assert property (p_ld_pen) else $error("misaligned load answered too early");

   property p_fault;
      ld_acc && !ld_al && I_ALIGN_MASK |-> ##2 (O_LD_DONE && O_LD_RSP.fault);
   endproperty
   a_fault: assert property (p_fault) else $error("alignment fault not raised");

   property p_fwd;
      fwd_go |=> O_LD_DONE && O_LD_RSP.fwd && !O_LD_RSP.fault;
   endproperty
   a_fwd: assert property (p_fwd) else $error("forwarded load not answered next cycle");

   property p_wait;
      state_q == slf_pkg::L_WAIT && valid_q[wait_q] |=> !O_DC_RD_VALID;
   endproperty
   a_wait: assert property (p_wait) else $error("cache read before store drained");

   property p_commit;
      O_DC_WR_VALID |-> pend_q != '0;
   endproperty
   a_commit: assert property (p_commit) else $error("store written before retirement");

   property p_start;
      fwd_go |-> (ent_q[sel2].acc.addr == ld_q.addr)
              || (ent_q[sel2].acc.size == slf_pkg::SZ_DQWORD
                  && ent_q[sel2].acc.addr + `SLF_UPPER_OFS == ld_q.addr);
   endproperty
   a_start: assert property (p_start) else $error("forward with mismatched start");

   property p_wide;
      fwd_go |-> ld_n <= slf_pkg::size_bytes(ent_q[sel2].acc.size);
   endproperty
   a_wide: assert property (p_wide) else $error("narrow store forwarded to wide load");

   property p_misal;
      fwd_go |-> slf_pkg::is_aligned(ld_q.addr[3:0], ld_q.size)
              && slf_pkg::is_aligned(ent_q[sel2].acc.addr[3:0], ent_q[sel2].acc.size);
   endproperty
   a_misal: assert property (p_misal) else $error("misaligned access forwarded");

   property p_retry;
      O_LD_RETRY |=> state_q == slf_pkg::L_LOOK ##1 !O_LD_RETRY;
   endproperty
   a_retry: assert property (p_retry) else $error("false match not retried once");

endmodule

`default_nettype wire

// >>> tb/slf_cache_model.sv
// data-cache partner: accepts store writes and answers load reads
// assumes the bench drives the retire pulses; read data is a pattern of the address
`timescale 1ns/1ps
`default_nettype none
`include "slf_defs.svh"

module slf_cache_model (
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   input  wire logic              i_slow,
   input  wire logic              i_wr_valid,
   output logic                   o_wr_ready,
   input  wire logic              i_rd_valid,
   input  wire slf_pkg::acc_t     i_rd,
   output logic                   o_rd_done,
   output logic [`SLF_DW-1:0]     o_rd_data
);
   // ==========================================================
   // answers
   logic [3:0] wait_q;
   logic       stall_q;
   logic [7:0] tag;
   logic [3:0] lim;
   assign tag = i_rd.addr[7:0];
   assign lim = i_slow ? 4'h5 : 4'h1;
   // outside the done cycle the data is inverted so a late sample shows up
   assign o_rd_data = o_rd_done ? {16{tag}} : ~{16{tag}};
   assign o_wr_ready = !i_slow || stall_q;
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wait_q <= 4'h0;
         stall_q <= 1'b0;
         o_rd_done <= 1'b0;
      end
      else
      begin
         // a slow write waits one cycle after valid rises
         stall_q <= i_wr_valid && !stall_q;
         o_rd_done <= i_rd_valid && !o_rd_done && (wait_q == lim);
         if (!i_rd_valid || o_rd_done || wait_q == lim)
            wait_q <= 4'h0;
         else
            wait_q <= wait_q + 4'h1;
      end
   end
endmodule
`default_nettype wire

// >>> tb/store_load_forward_test.sv
// self-checking bench for the forwarding block with a cache partner
// assumes one load at a time; the bench retires stores only when told to
`timescale 1ns/1ps
`default_nettype none
`include "slf_defs.svh"

module store_load_forward_test;
   logic clk, rst_n, mask, st_valid, retire, ld_valid, slow, auto_ret;
   logic st_ready, wr_valid, wr_ready, ld_ready, rd_valid, rd_done, ld_done, ld_retry;
   logic [`SLF_DW-1:0] rd_data;
   slf_pkg::st_req_t st, dc_wr;
   slf_pkg::acc_t ld, dc_rd;
   slf_pkg::ld_rsp_t rsp, r;
   slf_pkg::st_req_t sent[16];
   int n_mismatch, checks_done, n_st, n_ret, n_wr, cyc, wr_cyc, rd_first, lat, flat;
   logic b, retry_seen;

   store_load_forward dut_u (.I_MCLK(clk), .I_RST_N(rst_n), .I_ALIGN_MASK(mask),
      .I_ST_VALID(st_valid), .I_ST(st), .O_ST_READY(st_ready), .I_ROB_STORE_RETIRE(retire),
      .O_DC_WR_VALID(wr_valid), .O_DC_WR(dc_wr), .I_DC_WR_READY(wr_ready),
      .I_LD_VALID(ld_valid), .I_LD(ld), .O_LD_READY(ld_ready), .O_DC_RD_VALID(rd_valid),
      .O_DC_RD(dc_rd), .I_DC_RD_DONE(rd_done), .I_DC_RD_DATA(rd_data), .O_LD_DONE(ld_done),
      .O_LD_RSP(rsp), .O_LD_RETRY(ld_retry));
   slf_cache_model cache_u (.i_clk(clk), .i_rst_n(rst_n), .i_slow(slow),
      .i_wr_valid(wr_valid), .o_wr_ready(wr_ready), .i_rd_valid(rd_valid), .i_rd(dc_rd),
      .o_rd_done(rd_done), .o_rd_data(rd_data));

   // ==========================================================
   // helpers
   task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
      checks_done++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   function automatic logic [127:0] msk(input logic [127:0] d, input int n);
      msk = d & ((128'h1 << (8 * n)) - 128'h1);
   endfunction

   task automatic st_put(input logic [47:0] a, input slf_pkg::size_t s,
                         input logic [127:0] d, output logic bub);
      @(posedge clk);
      st_valid <= 1'b1;
      st <= '{acc: '{addr: a, size: s}, data: d};
      do @(posedge clk); while (st_ready !== 1'b1);
      st_valid <= 1'b0;
      sent[n_st] = st;
      n_st++;
      @(posedge clk);
      bub = st_ready;
   endtask

   // rel lets the retire pulses run while the load waits
   task automatic ld_do(input logic [47:0] a, input slf_pkg::size_t s, input logic rel);
      @(posedge clk);
      auto_ret <= rel;
      ld_valid <= 1'b1;
      ld <= '{addr: a, size: s};
      do @(posedge clk); while (ld_ready !== 1'b1);
      ld_valid <= 1'b0;
      lat = 0;
      do
      begin
         @(posedge clk);
         lat++;
      end
      while (ld_done !== 1'b1);
      r = rsp;
   endtask

   // retirement stops again so the next store stays buffered for its load
   task automatic drain;
      auto_ret <= 1'b1;
      do @(posedge clk); while (n_wr != n_st);
      auto_ret <= 1'b0;
   endtask

   function automatic logic [127:0] pat(input logic [47:0] a, input int n);
      pat = msk({16{a[7:0]}}, n);
   endfunction

   // ==========================================================
   // retire driver and cache-write monitor
   always @(posedge clk)
   begin
      cyc++;
      if (ld_retry === 1'b1) retry_seen = 1'b1;
      if (rd_valid === 1'b1 && rd_first == 0) rd_first = cyc;
      if (wr_valid === 1'b1 && wr_ready === 1'b1)
      begin
         chk("write after retire", 1, n_wr < n_ret);
         chk("write access", sent[n_wr].acc, dc_wr.acc);
         chk("write data", sent[n_wr].data, dc_wr.data);
         n_wr++;
         wr_cyc = cyc;
      end
      if (retire) n_ret++;
      retire <= auto_ret && !retire && (n_st > n_ret);
   end

   // ==========================================================
   // scenarios
   task automatic t_fwd;
      st_put(48'h100, slf_pkg::SZ_QWORD, 128'h1122_3344_5566_7788, b);
      chk("aligned store ready", 1, b);
      ld_do(48'h100, slf_pkg::SZ_DWORD, 0);
      chk("fwd flag", 1, r.fwd);
      chk("fwd data", 128'h5566_7788, r.data);
      flat = lat;
      chk("fwd not waiting", 1, lat < 8);
      drain();
      $display("test fwd done");
   endtask

   task automatic t_upper;
      st_put(48'h200, slf_pkg::SZ_DQWORD, 128'hA1A2_A3A4_A5A6_A7A8_B1B2_B3B4_B5B6_B7B8, b);
      ld_do(48'h208, slf_pkg::SZ_QWORD, 0);
      chk("upper fwd", 1, r.fwd);
      chk("upper data", 128'hA1A2_A3A4_A5A6_A7A8, r.data);
      ld_do(48'h204, slf_pkg::SZ_DWORD, 1);
      chk("offset refused", 0, r.fwd);
      chk("offset cache data", pat(48'h204, 4), r.data);
      drain();
      $display("test upper done");
   endtask

   task automatic t_wide;
      slow <= 1'b1;
      st_put(48'h300, slf_pkg::SZ_WORD, 128'hBEEF, b);
      rd_first = 0;
      ld_do(48'h300, slf_pkg::SZ_DWORD, 1);
      chk("wide refused", 0, r.fwd);
      chk("read after write", 1, rd_first > wr_cyc);
      chk("wide cache data", pat(48'h300, 4), r.data);
      slow <= 1'b0;
      drain();
      $display("test wide done");
   endtask

   task automatic t_misal;
      slf_pkg::size_t s;
      st_put(48'h30C, slf_pkg::SZ_QWORD, 128'h77, b);
      chk("misaligned store bubble", 0, b);
      ld_do(48'h30C, slf_pkg::SZ_QWORD, 1);
      chk("misaligned refused", 0, r.fwd);
      chk("no fault unmasked", 0, r.fault);
      drain();
      st_put(48'h318, slf_pkg::SZ_TBYTE, 128'h0102_0304_0506_0708_090A, b);
      chk("ten-byte aligned", 1, b);
      ld_do(48'h318, slf_pkg::SZ_QWORD, 0);
      chk("ten-byte fwd", 1, r.fwd);
      drain();
      mask <= 1'b1;
      for (int i = 1; i < 6; i++)
      begin
         s = slf_pkg::size_t'(i);
         ld_do(48'h501, s, 0);
         chk("fault misaligned", 1, r.fault);
         chk("fault data", 0, r.data);
         chk("fault latency", flat - 1, lat);
         ld_do((s == slf_pkg::SZ_TBYTE) ? 48'h508 : 48'h500, s, 0);
         chk("no fault aligned", 0, r.fault);
      end
      mask <= 1'b0;
      $display("test misal done");
   endtask

   task automatic t_bytes;
      st_put(48'h400, slf_pkg::SZ_BYTE, 128'h5A, b);
      ld_do(48'h400, slf_pkg::SZ_BYTE, 0);
      chk("single byte fwd", 1, r.fwd);
      chk("single byte data", 128'h5A, r.data);
      st_put(48'h401, slf_pkg::SZ_BYTE, 128'hC3, b);
      ld_do(48'h401, slf_pkg::SZ_BYTE, 0);
      chk("high byte fwd", 1, r.fwd);
      chk("high byte data", 128'hC3, r.data);
      ld_do(48'h400, slf_pkg::SZ_BYTE, 1);
      chk("low byte refused", 0, r.fwd);
      drain();
      $display("test bytes done");
   endtask

   task automatic t_young;
      st_put(48'h600, slf_pkg::SZ_DWORD, 128'h1111_1111, b);
      st_put(48'h600, slf_pkg::SZ_DWORD, 128'h2222_2222, b);
      ld_do(48'h600, slf_pkg::SZ_DWORD, 0);
      chk("youngest fwd", 128'h2222_2222, r.data);
      drain();
      slow <= 1'b1;
      st_put(48'h1010, slf_pkg::SZ_DWORD, 128'h99, b);
      retry_seen = 1'b0;
      ld_do(48'h2010, slf_pkg::SZ_DWORD, 0);
      chk("false match retry", 1, retry_seen);
      chk("false match no fwd", 0, r.fwd);
      chk("false match data", pat(48'h2010, 4), r.data);
      slow <= 1'b0;
      drain();
      $display("test young done");
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ==========================================================
   // run
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      end_sim();
   end

   initial
   begin
      {rst_n, mask, st_valid, retire, ld_valid, slow, auto_ret} = '0;
      st = '0;
      ld = '0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_fwd();
      t_upper();
      t_wide();
      t_misal();
      t_bytes();
      t_young();
      end_sim();
   end
endmodule
`default_nettype wire
